// ===== include/flash_cmd_defs.vh
// Constants for the serial flash command front end.
// Assumes inclusion by bare name from rtl modules; definitions only.
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH

// Opcodes that need special address handling
`define OP_MAIN_PAGE_READ    8'hd2
`define OP_LEGACY_CONT_READ  8'he8
`define OP_BUF1_READ_FAST    8'hd4
`define OP_BUF2_READ_FAST    8'hd6
`define OP_BUF1_READ_SLOW    8'hd1
`define OP_BUF2_READ_SLOW    8'hd3

// Don't-care byte counts after the address
`define DUMMY_MAIN_READ      3'd4
`define DUMMY_BUF_FAST       3'd1
`define DUMMY_NONE           3'd0

// Address field layout, 528-byte page mode
`define ADDR_BYTES           2'd3
`define PAGE_NUM_MSB         22
`define PAGE_NUM_LSB         10
`define BYTE_OFS_MSB         9
`define BYTE_OFS_LSB         0

// Clock mode codes
`define CLK_MODE_0           1'b0
`define CLK_MODE_3           1'b1

// Power-up timing, in microseconds, and clock rate in MHz
`define CLK_MHZ              50
`define SUPPLY_TO_SELECT_US  70
`define POWERUP_WRITE_US     20000
`endif

// ===== rtl/pin_sync.v
// Three-stage synchroniser with agreement filter for one pin.
// Assumes clk is the block clock; pin is asynchronous to it.
`timescale 1ns/1ps
module pin_sync #(
   parameter RESET_LEVEL = 1'b1
) (
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Pin in, filtered level out
   input  wire pin,
   output reg  level
);
   reg s1;
   reg s2;
   reg s3;

   // First stage feeds only the second; level moves when stages 2 and 3 agree
   always @(posedge clk) begin
      if (rst) begin
         s1    <= RESET_LEVEL;
         s2    <= RESET_LEVEL;
         s3    <= RESET_LEVEL;
         level <= RESET_LEVEL;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end
endmodule

// ===== rtl/flash_cmd_front.v
// Serial command front end of a page-organised flash, 528-byte page mode.
// Assumes the SPI pins arrive asynchronously and are oversampled by clk;
// the array and buffers sit behind the decoded command outputs.
//
// What this block does
// - The three address bytes carry one reserved bit, a 13-bit page number, then a 10-bit offset, MSB first.
// - Main-page read and legacy continuous read take page and byte address, then four don't-care bytes before output.
// - The fast buffer reads take an offset plus one don't-care byte; the slow buffer reads take none.
// - After power-up or reset the clock mode defaults to mode 3.
// - After power-up or reset the serial output stays high-impedance until a command drives it.
// - No instruction is accepted until the synchronised chip select falls; a select held low across an rst release reads as a fall.
// - Each chip-select fall samples the idle clock level: high picks mode 3, low mode 0.
// - While power-on reset is held, every operation is disabled and every command ignored.
// - After power-up the device sits in standby, neither deep power-down nor busy.
`timescale 1ns/1ps
`include "flash_cmd_defs.vh"
module flash_cmd_front #(
   parameter SELECT_CYCLES = `SUPPLY_TO_SELECT_US * `CLK_MHZ,
   parameter WRITE_CYCLES  = `POWERUP_WRITE_US * `CLK_MHZ
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Power-on reset from the supply monitor, high while below threshold
   input  wire        por_active,
   // Serial pins from the host
   input  wire        cs_n,
   input  wire        sck,
   input  wire        si,
   // Serial output pin, three signals
   output reg         so_out,
   output reg         so_oe,
   input  wire        so_in,
   // Read data from the array side, next byte to shift out
   input  wire [7:0]  read_byte,
   // Decoded command
   output reg  [7:0]  opcode,
   output reg  [12:0] page_number,
   output reg  [9:0]  byte_offset,
   output reg         cmd_valid,
   output reg         read_start,
   // Status
   output reg         clk_mode,
   output reg         standby,
   output reg         deep_power_down,
   output reg         busy,
   output reg         select_allowed,
   output reg         write_allowed
);
   // States
   localparam ST_ARMED = 3'd0;
   localparam ST_OPC   = 3'd1;
   localparam ST_ADDR  = 3'd2;
   localparam ST_DUMMY = 3'd3;
   localparam ST_DATA  = 3'd4;
   localparam ST_WAIT  = 3'd5;

   wire       cs_l;
   wire       sck_l;
   wire       si_l;
   reg        cs_q;
   reg        sck_q;
   reg        seen_fall;
   reg  [2:0] state;
   reg  [2:0] bit_cnt;
   reg  [1:0] addr_cnt;
   reg  [2:0] dummy_cnt;
   reg  [7:0] shift_in;
   reg  [7:0] shift_out;
   reg [23:0] addr;
   reg [31:0] sel_cnt;
   reg [31:0] wr_cnt;

   pin_sync #(.RESET_LEVEL(1'b1)) u_cs  (.clk(clk), .rst(rst), .pin(cs_n), .level(cs_l));
   pin_sync #(.RESET_LEVEL(1'b1)) u_sck (.clk(clk), .rst(rst), .pin(sck),  .level(sck_l));
   pin_sync #(.RESET_LEVEL(1'b0)) u_si  (.clk(clk), .rst(rst), .pin(si),   .level(si_l));

   wire cs_fall  = cs_q & ~cs_l;
   wire sck_rise = ~sck_q & sck_l;
   wire sck_fall = sck_q & ~sck_l;
   wire [7:0] byte_in = {shift_in[6:0], si_l};

   // Don't-care byte count per opcode
   function [2:0] dummy_bytes;
      input [7:0] op;
      begin
         case (op)
            `OP_MAIN_PAGE_READ, `OP_LEGACY_CONT_READ: dummy_bytes = `DUMMY_MAIN_READ;
            `OP_BUF1_READ_FAST, `OP_BUF2_READ_FAST:   dummy_bytes = `DUMMY_BUF_FAST;
            default:                                  dummy_bytes = `DUMMY_NONE;
         endcase
      end
   endfunction

   // Which opcodes return data
   function is_read;
      input [7:0] op;
      begin
         is_read = (op == `OP_MAIN_PAGE_READ) || (op == `OP_LEGACY_CONT_READ) ||
                   (op == `OP_BUF1_READ_FAST) || (op == `OP_BUF2_READ_FAST) ||
                   (op == `OP_BUF1_READ_SLOW) || (op == `OP_BUF2_READ_SLOW);
      end
   endfunction

   // Power-up timers; long counts are parameters so benches can shorten them
   always @(posedge clk) begin
      if (rst || por_active) begin
         sel_cnt        <= 32'h0;
         wr_cnt         <= 32'h0;
         select_allowed <= 1'b0;
         write_allowed  <= 1'b0;
      end else begin
         if (sel_cnt < SELECT_CYCLES) begin
            sel_cnt <= sel_cnt + 32'h1;
         end else begin
            select_allowed <= 1'b1;
         end
         if (wr_cnt < WRITE_CYCLES) begin
            wr_cnt <= wr_cnt + 32'h1;
         end else begin
            write_allowed <= 1'b1;
         end
      end
   end

   // Command engine; sampling on the edge that suits the picked mode is
   // unnecessary since modes 0 and 3 both sample on rising and drive on falling
   always @(posedge clk) begin
      if (rst || por_active) begin
         cs_q            <= 1'b0;   // Select held low across a por_active release is no fall; an rst release still shows one
         sck_q           <= 1'b1;
         seen_fall       <= 1'b0;
         state           <= ST_ARMED;
         bit_cnt         <= 3'h0;
         addr_cnt        <= 2'h0;
         dummy_cnt       <= 3'h0;
         shift_in        <= 8'h00;
         shift_out       <= 8'h00;
         addr            <= 24'h000000;
         opcode          <= 8'h00;
         page_number     <= 13'h0000;
         byte_offset     <= 10'h000;
         cmd_valid       <= 1'b0;
         read_start      <= 1'b0;
         so_out          <= 1'b0;
         so_oe           <= 1'b0;
         clk_mode        <= `CLK_MODE_3;
         standby         <= 1'b1;
         deep_power_down <= 1'b0;
         busy            <= 1'b0;
      end else begin
         cs_q       <= cs_l;
         sck_q      <= sck_l;
         cmd_valid  <= 1'b0;
         read_start <= 1'b0;
         if (cs_l) begin
            // Deselect ends any transfer and releases the output
            state <= ST_ARMED;
            so_oe <= 1'b0;
         end else if (cs_fall) begin
            seen_fall <= 1'b1;
            clk_mode  <= sck_l;
            state     <= ST_OPC;
            bit_cnt   <= 3'h0;
            addr_cnt  <= 2'h0;
         end else if (seen_fall && sck_rise) begin
            shift_in <= byte_in;
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               case (state)
                  ST_OPC: begin
                     opcode <= byte_in;
                     state  <= ST_ADDR;
                  end
                  ST_ADDR: begin
                     addr     <= {addr[15:0], byte_in};
                     addr_cnt <= addr_cnt + 2'h1;
                     if (addr_cnt == `ADDR_BYTES - 2'd1) begin
                        page_number <= addr[`PAGE_NUM_MSB-8:`PAGE_NUM_LSB-8];
                        byte_offset <= {addr[1:0], byte_in};
                        cmd_valid   <= 1'b1;
                        dummy_cnt   <= dummy_bytes(opcode);
                        if (!is_read(opcode)) begin
                           state <= ST_WAIT;
                        end else if (dummy_bytes(opcode) == `DUMMY_NONE) begin
                           state      <= ST_DATA;
                           read_start <= 1'b1;
                        end else begin
                           state <= ST_DUMMY;
                        end
                     end
                  end
                  ST_DUMMY: begin
                     dummy_cnt <= dummy_cnt - 3'h1;
                     if (dummy_cnt == 3'h1) begin
                        state      <= ST_DATA;
                        read_start <= 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end else if (state == ST_DATA && sck_fall) begin
            // Output driven only once address and dummy bytes are in
            so_oe <= 1'b1;
            if (bit_cnt == 3'h0) begin
               so_out    <= read_byte[7];
               shift_out <= {read_byte[6:0], 1'b0};
            end else begin
               so_out    <= shift_out[7];
               shift_out <= {shift_out[6:0], 1'b0};
            end
         end
      end
   end
endmodule

// ===== testbench/flash_front_props.sv
// Port checker for the flash command front end.
// Assumes a bind to flash_cmd_front; one clock domain.
`timescale 1ns/1ps
module flash_front_props (
   // Clock and resets
   input logic       clk,
   input logic       rst,
   input logic       por_active,
   // Pins and outputs watched
   input logic       cs_n,
   input logic       sck,
   input logic       so_oe,
   input logic [7:0] opcode,
   input logic       cmd_valid,
   input logic       read_start,
   input logic       clk_mode,
   input logic       standby,
   input logic       busy,
   input logic       deep_power_down
);
   default clocking @(posedge clk); endclocking
   // Read classes; only these may drive the pin
   wire slow = opcode == 8'hd1 || opcode == 8'hd3;
   wire dum  = opcode == 8'hd2 || opcode == 8'he8 || opcode == 8'hd4 || opcode == 8'hd6;
   a_reset_state: assert property (rst |=> !so_oe && clk_mode && standby && !busy && !deep_power_down)
      else $error("bad state after reset");
   a_por_quiet: assert property (por_active |=> !cmd_valid && !read_start && !so_oe)
      else $error("activity under power-on reset");
   a_oe_idle: assert property (disable iff (rst) cs_n [*8] |-> !so_oe)
      else $error("pin driven while deselected");
   a_mode_three: assert property (disable iff (rst || por_active) (cs_n && sck) [*6] ##1 !cs_n |-> ##6 clk_mode)
      else $error("high idle clock not taken as mode 3");
   a_mode_zero: assert property (disable iff (rst || por_active) (cs_n && !sck) [*6] ##1 !cs_n |-> ##6 !clk_mode)
      else $error("low idle clock not taken as mode 0");
   a_slow_start: assert property (disable iff (rst) cmd_valid && slow |-> read_start)
      else $error("slow buffer read delayed");
   a_dummy_gap: assert property (disable iff (rst) cmd_valid && dum |=> !read_start [*8])
      else $error("data before dummy bytes");
   a_oe_read: assert property (disable iff (rst) $rose(so_oe) |-> slow || dum)
      else $error("non-read command drove pin");
endmodule
bind flash_cmd_front flash_front_props i_props (.clk(clk), .rst(rst), .por_active(por_active), .cs_n(cs_n),
   .sck(sck), .so_oe(so_oe), .opcode(opcode), .cmd_valid(cmd_valid), .read_start(read_start),
   .clk_mode(clk_mode), .standby(standby), .busy(busy), .deep_power_down(deep_power_down));

// ===== testbench/spi_host_model.sv
// Behavioural serial host framing commands for the front end.
// Assumes clk is the block clock; pins move on its falling edge.
`timescale 1ns/1ps
module spi_host_model (
   // Timing reference
   input  wire clk,
   // Serial pins
   output reg  cs_n,
   output reg  sck,
   output reg  si,
   input  wire so
);
   integer nbits;
   initial begin
      cs_n = 1'b1;
      sck = 1'b1;
      si = 1'b0;
      nbits = 0;
   end
   // One frame; link clock 160 ns, still outside frames; so read late in high phase
   task frame(input [7:0] op, input [23:0] adr, input [2:0] nd, input hi, output [7:0] rx);
      reg [63:0] sh;
      integer i, n;
      begin
         sh = {op, adr, 32'h0};
         n = 40 + 8 * nd;
         sck = hi;
         repeat (8) @(negedge clk);
         cs_n = 1'b0;
         nbits = 0;
         repeat (4) @(negedge clk);
         for (i = 0; i < n; i = i + 1) begin
            sck = 1'b0;
            si = (i < 64) ? sh[63 - i] : ~si;
            repeat (4) @(negedge clk);
            sck = 1'b1;
            nbits = nbits + 1;
            repeat (3) @(negedge clk);
            if (i >= n - 8) rx = {rx[6:0], so};
            @(negedge clk);
         end
         sck = hi;
         repeat (4) @(negedge clk);
         cs_n = 1'b1;
         si = ~si;
         // Let the deselect reach the device before the caller looks
         repeat (8) @(negedge clk);
      end
   endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the flash command front end.
// Assumes spi_host_model as far side; 50 MHz clock.
`timescale 1ns/1ps
module tb;
   localparam SEL = 20;
   localparam WR  = 50;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         por_active = 1'b0;
   reg  [7:0]  read_byte = 8'h00;
   reg  [7:0]  rx;
   wire        cs_n, sck, si, so_out, so_oe, cmd_valid, read_start;
   wire        clk_mode, standby, deep_power_down, busy, select_allowed, write_allowed;
   wire [7:0]  opcode;
   wire [12:0] page_number;
   wire [9:0]  byte_offset;
   // Released pin shows the inverse bit, never a stale one
   wire        so_line = so_oe ? so_out : ~so_out;
   integer     err_total = 0, tests_run = 0, cycles = 0, n_cv, n_rs, cv_at, rs_at, oe_seen;
   flash_cmd_front #(.SELECT_CYCLES(SEL), .WRITE_CYCLES(WR)) i_flash_cmd_front (.clk(clk), .rst(rst),
      .por_active(por_active), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe), .so_in(so_line),
      .read_byte(read_byte), .opcode(opcode), .page_number(page_number), .byte_offset(byte_offset),
      .cmd_valid(cmd_valid), .read_start(read_start), .clk_mode(clk_mode), .standby(standby),
      .deep_power_down(deep_power_down), .busy(busy), .select_allowed(select_allowed),
      .write_allowed(write_allowed));
   spi_host_model i_spi_host_model (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
   always #10 clk = ~clk;
   // Pulse monitor and hang guard
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cmd_valid === 1'b1) begin
         n_cv = n_cv + 1;
         cv_at = i_spi_host_model.nbits;
      end
      if (read_start === 1'b1) begin
         n_rs = n_rs + 1;
         rs_at = i_spi_host_model.nbits;
      end
      if (so_oe !== 1'b0) oe_seen = 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         close_out;
      end
   end
   task chk(input [23:0] got, input [23:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("Checks %0d, mismatches %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Idle state, then the select and write delays
   task t_idle;
      integer c, s_at, w_at;
      begin
         s_at = 0;
         w_at = 0;
         chk({so_oe, clk_mode, standby, busy, deep_power_down}, 5'b01100);
         for (c = 1; c < WR + 10; c = c + 1) begin
            @(negedge clk);
            if (select_allowed === 1'b1 && s_at == 0) s_at = c;
            if (write_allowed === 1'b1 && w_at == 0) w_at = c;
         end
         chk(s_at >= SEL && s_at <= SEL + 4, 1);
         chk(w_at >= WR && w_at <= WR + 4, 1);
         $display("idle test done");
      end
   endtask
   // Read of any kind; n_cv/n_rs count pulses, *_at the link edges seen
   task t_read(input [7:0] op, input [23:0] adr, input [2:0] nd, input hi, input [7:0] rb);
      begin
         n_cv = 0;
         n_rs = 0;
         read_byte = rb;
         i_spi_host_model.frame(op, adr, nd, hi, rx);
         chk(opcode, op);
         chk(byte_offset, adr[9:0]);
         if (nd == 3'd4) chk(page_number, adr[22:10]);
         chk(clk_mode, hi);
         // Sized product keeps the expected word at 24 bits
         chk({n_cv[3:0], n_rs[3:0], cv_at[7:0], rs_at[7:0]}, {8'h11, 8'd32, 8'd32 + 8'd8 * nd});
         chk(rx, rb);
         $display("read test %h done", op);
      end
   endtask
   // Program command: no read pulse, pin never driven; reserved bit set high
   task t_write;
      begin
         n_cv = 0;
         n_rs = 0;
         oe_seen = 0;
         while (write_allowed !== 1'b1) @(negedge clk);
         i_spi_host_model.frame(8'h83, 24'hfffc00, 3'd0, 1'b1, rx);
         chk({n_cv[3:0], n_rs[3:0], oe_seen[0]}, 9'h020);
         chk(page_number, 24'h001fff);
         $display("write test done");
      end
   endtask
   // Frame under power-on reset, released mid-frame: with no fresh select
   // fall the rest is ignored too, and the mode stays at 3 despite a low clock
   task t_por;
      begin
         n_cv = 0;
         n_rs = 0;
         oe_seen = 0;
         por_active = 1'b1;
         fork
            i_spi_host_model.frame(8'hd2, 24'h123456, 3'd4, 1'b0, rx);
            begin
               repeat (100) @(negedge clk);
               por_active = 1'b0;
            end
         join
         chk({n_cv[3:0], n_rs[3:0], oe_seen[0], clk_mode, standby, busy}, 12'h006);
         while (select_allowed !== 1'b1) @(negedge clk);
         t_read(8'hd2, 24'h2aaa55, 3'd4, 1'b0, 8'h96);
         $display("power-on test done");
      end
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_idle;
      t_read(8'hd2, {1'b0, 13'h1a5c, 10'h2a5}, 3'd4, 1'b0, 8'ha5);
      t_read(8'he8, {1'b0, 13'h1fff, 10'h000}, 3'd4, 1'b1, 8'h3c);
      t_read(8'hd4, 24'h0003ff, 3'd1, 1'b1, 8'h81);
      t_read(8'hd6, 24'h000200, 3'd1, 1'b0, 8'h7e);
      t_read(8'hd1, 24'h000155, 3'd0, 1'b1, 8'hc3);
      t_write;
      t_read(8'hd3, 24'h0002aa, 3'd0, 1'b0, 8'h18);
      t_por;
      close_out;
   end
endmodule
